// File: rtl/caf_consts.vh
// constants for the can acceptance filter block
`ifndef CAF_CONSTS_VH
`define CAF_CONSTS_VH
// ----------------------------------------
// register map (byte offsets)
// ----------------------------------------
`define CAF_MASK_BASE 8'h00
`define CAF_FCON_BASE 8'h40
`define CAF_FID_BASE 8'h80
`define CAF_CTRL_OFF 8'hC0
`define CAF_STAT_OFF 8'hD0
`define CAF_ALIAS_CLR 2'h1
`define CAF_ALIAS_SET 2'h2
`define CAF_ALIAS_INV 2'h3
// ----------------------------------------
// fields
// ----------------------------------------
`define CAF_MASK_VALID 32'hFFEBFFFF
`define CAF_FID_VALID 32'hFFEBFFFF
`define CAF_IDE_BIT 19
`define CAF_CFG_MODE 3'h4
`define CAF_MODE_LSB 21
`define CAF_RESET_MODE 3'h4
`endif

// File: rtl/caf_filter.v
// can receive acceptance filter with axi4-lite register bank
`timescale 1ns/100ps
`include "caf_consts.vh"
module caf_filter #(
  parameter NFILT = 32
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [28:0] rx_id,
  input wire rx_ext,
  input wire rx_valid,
  output reg fifo_wr,
  output reg [4:0] fifo_num,
  output reg [4:0] fifo_hit_filter,
  output wire [2:0] operating_mode_field
);
// ----------------------------------------
// registers
// ----------------------------------------
reg [31:0] mask_q [0:3];
reg [7:0] fcon_q [0:NFILT-1];
reg [31:0] fid_q [0:NFILT-1];
reg [31:0] ctrl_q;
reg [31:0] last_q;
reg [31:0] awaddr_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg aw_have_q;
reg w_have_q;
assign operating_mode_field = ctrl_q[23:21];
wire cfg_mode = (operating_mode_field == `CAF_CFG_MODE);
// ----------------------------------------
// alias write merge
// ----------------------------------------
function [31:0] alias_val;
  input [31:0] old;
  input [31:0] wd;
  input [1:0] kind;
  begin
    case (kind)
      `CAF_ALIAS_CLR: alias_val = old & ~wd;
      `CAF_ALIAS_SET: alias_val = old | wd;
      `CAF_ALIAS_INV: alias_val = old ^ wd;
      default: alias_val = wd;
    endcase
  end
endfunction
function [31:0] lanes;
  input [3:0] st;
  begin
    lanes = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
  end
endfunction
function lanes_ok;
  input [3:0] st;
  begin
    case (st)
      4'hF: lanes_ok = 1'b1;
      4'h3: lanes_ok = 1'b1;
      4'hC: lanes_ok = 1'b1;
      default: lanes_ok = 1'b0;
    endcase
  end
endfunction
function [31:0] merge;
  input [31:0] cur_v;
  input [31:0] dat;
  input [1:0] kd;
  input [31:0] keep;
  begin
    merge = (cur_v & ~keep) | (alias_val(cur_v, dat, kd) & keep);
  end
endfunction
// ----------------------------------------
// address decode
// ----------------------------------------
localparam RG_MASK = 3'h0;
localparam RG_FCON = 3'h1;
localparam RG_FID = 3'h2;
localparam RG_CTRL = 3'h3;
localparam RG_STAT = 3'h4;
localparam RG_NONE = 3'h7;
function [2:0] region;
  input [31:0] addr;
  reg [7:0] base;
  begin
    base = {addr[7:4], 4'h0};
    case (base[7:6])
      2'b00: region = RG_MASK;
      2'b01: region = RG_FCON;
      2'b10: region = RG_FID;
      default: begin
        if (base == `CAF_CTRL_OFF) begin
          region = RG_CTRL;
        end else if (base == `CAF_STAT_OFF) begin
          region = RG_STAT;
        end else begin
          region = RG_NONE;
        end
      end
    endcase
  end
endfunction
function [4:0] slot;
  input [31:0] addr;
  begin
    slot = {3'h0, addr[5:4]};
  end
endfunction
function [4:0] pair_lo;
  input [31:0] addr;
  begin
    pair_lo = {2'h0, addr[5:4], 1'b0};
  end
endfunction
function [4:0] pair_hi;
  input [31:0] addr;
  begin
    pair_hi = {2'h0, addr[5:4], 1'b1};
  end
endfunction
// ----------------------------------------
// write channel
// ----------------------------------------
assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
assign s_axi_wready = !w_have_q && !s_axi_bvalid;
wire [31:0] wa = aw_have_q ? awaddr_q : s_axi_awaddr;
wire [31:0] wd = w_have_q ? wdata_q : s_axi_wdata;
wire [3:0] ws = w_have_q ? wstrb_q : s_axi_wstrb;
wire aw_take = s_axi_awvalid && s_axi_awready;
wire w_take = s_axi_wvalid && s_axi_wready;
wire aw_ok = aw_have_q || aw_take;
wire w_ok = w_have_q || w_take;
wire wr_go = aw_ok && w_ok;
wire wide_ok = lanes_ok(ws);
wire [1:0] wk = wa[3:2];
wire [2:0] wrg = region(wa);
wire [31:0] wm = lanes(ws);
wire wr_mask = wr_go && wide_ok && (wrg == RG_MASK) && cfg_mode;
wire wr_fcon = wr_go && wide_ok && (wrg == RG_FCON);
wire wr_fid = wr_go && wide_ok && (wrg == RG_FID);
wire wr_ctrl = wr_go && wide_ok && (wrg == RG_CTRL);
wire w_unmapped = (wrg == RG_STAT) || (wrg == RG_NONE);
wire [4:0] w_lo = pair_lo(wa);
wire [4:0] w_hi = pair_hi(wa);
wire [4:0] w_slot = slot(wa);
wire [31:0] cur_mask = mask_q[w_slot[1:0]];
wire [31:0] cur_fid = fid_q[w_slot];
wire [31:0] cur_fc = {16'h0, fcon_q[w_hi], fcon_q[w_lo]};
// ----------------------------------------
// merged write values
// ----------------------------------------
wire [31:0] nv_mask = merge(cur_mask, wd, wk, wm);
wire [31:0] nv_fid = merge(cur_fid, wd, wk, wm);
wire [31:0] nv_fc = merge(cur_fc, wd, wk, wm);
wire [31:0] nv_ctrl = merge(ctrl_q, wd, wk, wm);
wire [31:0] mask_wr = nv_mask & `CAF_MASK_VALID;
wire [31:0] fid_wr = nv_fid & `CAF_FID_VALID;
wire [31:0] ctrl_wr = nv_ctrl & 32'h00E00000;
wire lo_locked = fcon_q[w_lo][7];
wire hi_locked = fcon_q[w_hi][7];
wire lo_en = nv_fc[7];
wire hi_en = nv_fc[15];
wire [6:0] lo_cfg = nv_fc[6:0];
wire [6:0] hi_cfg = nv_fc[14:8];
// ----------------------------------------
// register update
// ----------------------------------------
integer k;
always @(posedge aclk) begin
  if (!aresetn) begin
    aw_have_q <= 1'b0;
    w_have_q <= 1'b0;
    awaddr_q <= 32'h0;
    wdata_q <= 32'h0;
    wstrb_q <= 4'h0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= 2'h0;
    ctrl_q <= {8'h0, `CAF_RESET_MODE, 21'h0};
    for (k = 0; k < 4; k = k + 1) begin
      mask_q[k] <= 32'h0;
    end
    for (k = 0; k < NFILT; k = k + 1) begin
      fcon_q[k] <= 8'h0;
      fid_q[k] <= 32'h0;
    end
  end else begin
    if (s_axi_awvalid && s_axi_awready && !wr_go) begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready && !wr_go) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    if (wr_go) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= w_unmapped ? 2'h2 : 2'h0;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
    if (wr_mask) begin
      mask_q[w_slot[1:0]] <= mask_wr;
    end
    if (wr_fid) begin
      fid_q[w_slot] <= fid_wr;
    end
    if (wr_ctrl) begin
      ctrl_q <= ctrl_wr;
    end
    if (wr_fcon) begin
      // lower filter of the pair in bits 7..0, upper in 15..8
      if (!lo_locked) begin
        fcon_q[w_lo][6:0] <= lo_cfg;
      end
      fcon_q[w_lo][7] <= lo_en;
      if (!hi_locked) begin
        fcon_q[w_hi][6:0] <= hi_cfg;
      end
      fcon_q[w_hi][7] <= hi_en;
    end
  end
end
// ----------------------------------------
// read channel
// ----------------------------------------
assign s_axi_arready = !s_axi_rvalid;
wire [2:0] rrg = region(s_axi_araddr);
wire [4:0] r_lo = pair_lo(s_axi_araddr);
wire [4:0] r_hi = pair_hi(s_axi_araddr);
wire [4:0] r_slot = slot(s_axi_araddr);
wire r_take = s_axi_arvalid && s_axi_arready;
reg [31:0] rdata_d;
reg [1:0] rresp_d;
// ----------------------------------------
// read data select
// ----------------------------------------
always @* begin
  rdata_d = 32'h0;
  rresp_d = 2'h0;
  case (rrg)
    RG_MASK: rdata_d = mask_q[r_slot[1:0]];
    RG_FCON: rdata_d = {16'h0, fcon_q[r_hi], fcon_q[r_lo]};
    RG_FID: rdata_d = fid_q[r_slot];
    RG_CTRL: rdata_d = ctrl_q;
    RG_STAT: rdata_d = last_q;
    default: rresp_d = 2'h2;
  endcase
end
always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h0;
    s_axi_rresp <= 2'h0;
  end else if (r_take) begin
    s_axi_rvalid <= 1'b1;
    s_axi_rdata <= rdata_d;
    s_axi_rresp <= rresp_d;
  end else if (s_axi_rready) begin
    s_axi_rvalid <= 1'b0;
  end
end
// ----------------------------------------
// match logic
// ----------------------------------------
wire [10:0] rx_sid = rx_id[28:18];
wire [17:0] rx_eid = rx_id[17:0];
wire [NFILT-1:0] hit;
genvar g;
generate
  for (g = 0; g < NFILT; g = g + 1) begin : g_f
    wire en = fcon_q[g][7];
    wire [1:0] msel = fcon_q[g][6:5];
    wire [31:0] m = mask_q[msel];
    wire [31:0] f = fid_q[g];
    wire type_on = m[`CAF_IDE_BIT];
    wire want_ext = f[`CAF_IDE_BIT];
    wire sid_ok = ((f[31:21] ^ rx_sid) & m[31:21]) == 11'h0;
    wire eid_ok = ((f[17:0] ^ rx_eid) & m[17:0]) == 18'h0;
    wire type_ok = !type_on || (want_ext == rx_ext);
    // standard frames compare only the standard bits when types are free
    wire id_ok = sid_ok && (eid_ok || (!type_on && !rx_ext));
    assign hit[g] = en && type_ok && id_ok;
  end
endgenerate
// ----------------------------------------
// priority select
// ----------------------------------------
reg [4:0] sel_d;
reg [4:0] selfi_d;
reg any_d;
integer j;
always @* begin
  sel_d = 5'h0;
  selfi_d = 5'h0;
  any_d = 1'b0;
  for (j = NFILT - 1; j >= 0; j = j - 1) begin
    if (hit[j]) begin
      any_d = 1'b1;
      sel_d = fcon_q[j][4:0];
      selfi_d = j[4:0];
    end
  end
end
// ----------------------------------------
// fifo write path
// ----------------------------------------
wire accept_d = rx_valid && any_d && !cfg_mode;
wire [31:0] stat_d = {16'h0, 3'h0, selfi_d, 3'h1, sel_d};
always @(posedge aclk) begin
  if (!aresetn) begin
    fifo_wr <= 1'b0;
    fifo_num <= 5'h0;
    fifo_hit_filter <= 5'h0;
    last_q <= 32'h0;
  end else begin
    fifo_wr <= accept_d;
    if (accept_d) begin
      fifo_num <= sel_d;
      fifo_hit_filter <= selfi_d;
      last_q <= stat_d;
    end
  end
end
endmodule

// File: tb/caf_can_node.sv
// far-side can node model handing received ids to the filter
`timescale 1ns/100ps
module caf_can_node (
  input wire logic aclk,
  input wire logic go,
  input wire logic [29:0] go_msg,
  output logic [28:0] rx_id,
  output logic rx_ext,
  output logic rx_valid
);
  initial {rx_valid, rx_ext, rx_id} = 31'h00000000;
  // idle id lines wander so stale ids never look valid
  always @(posedge aclk) begin
    rx_valid <= go;
    {rx_ext, rx_id} <= go ? go_msg : ~{rx_ext, rx_id};
  end
endmodule

// File: tb/caf_filter_props.sv
// port assertions for the acceptance filter
`timescale 1ns/100ps
module caf_filter_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic rx_valid,
  input wire logic fifo_wr,
  input wire logic [4:0] fifo_num,
  input wire logic [2:0] operating_mode_field
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wr_cause_a: assert property (fifo_wr |-> $past(rx_valid))
    else $error("store without a received id");
  cfg_quiet_a: assert property (rx_valid && operating_mode_field == 3'h4 |=> !fifo_wr)
    else $error("store in configuration mode");
  wr_once_a: assert property (fifo_wr && !rx_valid |=> !fifo_wr)
    else $error("message stored twice");
  num_hold_a: assert property (!fifo_wr |-> $stable(fifo_num))
    else $error("fifo number moved without a store");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  b_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  r_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  cover property (fifo_wr);
  cover property (fifo_wr && fifo_num == 5'h1F);
  cover property (rx_valid && operating_mode_field == 3'h4);
endmodule
bind caf_filter caf_filter_props u_caf_filter_props (.*);

// File: tb/caf_filter_tb.sv
// self-checking bench for the acceptance filter
`timescale 1ns/100ps
`include "caf_consts.vh"
module caf_filter_tb;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, go = 0, cfg = 1;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, rd_data, v;
  logic [3:0] s_axi_wstrb = 0;
  logic [29:0] go_msg = 0;
  logic [1:0] rd_resp, wr_resp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire rx_ext, rx_valid, fifo_wr;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [28:0] rx_id;
  wire [4:0] fifo_num, fifo_hit_filter;
  wire [2:0] operating_mode_field;
  int mismatches = 0, checked = 0;
  logic [31:0] msk [4], fid [4], fc [4];
  always #5 aclk = ~aclk;
  caf_filter u_caf_filter (.*);
  caf_can_node u_caf_can_node (.*);
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, d, input logic [3:0] s = 4'hF);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  function automatic logic [31:0] fcx(logic [31:0] o, n);
    for (int h = 0; h < 16; h += 8)
      if (!o[h+7]) o[h+:7] = n[h+:7];
    return o;
  endfunction
  function automatic logic [8:0] hit(logic [29:0] m);
    logic [31:0] k, f, mm;
    hit = 0;
    for (int n = 7; n >= 0; n--) begin
      k = fc[n/2] >> (8 * (n % 2));
      f = n < 4 ? fid[n] : 0;
      mm = msk[k[6:5]];
      if (k[7] && ((m[28:18] ^ f[31:21]) & mm[31:21]) == 0
          && ((!m[29] && !mm[19]) || ((m[17:0] ^ f[17:0]) & mm[17:0]) == 0)
          && (!mm[19] || m[29] == f[19]))
        hit = {1'b1, n[2:0], k[4:0]};
    end
    if (cfg) hit = 0;
  endfunction
  task automatic send(input logic [29:0] m);
    logic [8:0] e;
    e = hit(m);
    @(posedge aclk);
    go <= 1;
    go_msg <= m;
    @(posedge aclk);
    go <= 0;
    @(posedge aclk);
    @(negedge aclk);
    chk(fifo_wr, e[8]);
    if (e[8]) chk({fifo_hit_filter, fifo_num}, {2'b0, e[7:0]});
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #600000;
    mismatches++;
    wrap_up;
  end
  initial begin
    v = $urandom(32'h95695607);
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(negedge aclk);
    chk(operating_mode_field, 3'h4);
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      wr(16 * i, v);
      msk[i] = v & `CAF_MASK_VALID;
      v = $urandom;
      wr(`CAF_FID_BASE + 16 * i, v);
      fid[i] = v & `CAF_FID_VALID;
      v = $urandom & 32'hFFFF;
      wr(`CAF_FCON_BASE + 16 * i, v);
      wr(`CAF_FCON_BASE + 16 * i, v ^ 32'h7F7F);
      fc[i] = fcx(v, v ^ 32'h7F7F);
      rd(16 * i);
      chk(rd_data, msk[i]);
      rd(`CAF_FCON_BASE + 16 * i);
      chk(rd_data, fc[i]);
    end
    wr(0, 32'hFFFFFFFF, 4'h1);
    wr(0, ~msk[0], 4'h3);
    wr(32'hC, 32'h00080001);
    msk[0] = msk[0] ^ 32'h0008FFFE;
    rd(0);
    chk(rd_data, msk[0]);
    for (int i = 0; i < 300; i++) begin
      if (i == 6) begin
        wr(`CAF_CTRL_OFF, 0);
        cfg = 0;
        wr(0, ~msk[0]);
        rd(0);
        chk(rd_data, msk[0]);
      end
      v = fid[$urandom % 4];
      go_msg = {v[19] ^ ($urandom % 8 == 0), v[31:21], v[17:0]};
      if ($urandom % 2) go_msg[$urandom % 29] ^= 1'b1;
      send(go_msg);
    end
    rd(32'hF0);
    chk(rd_resp, 2'h2);
    wr(`CAF_STAT_OFF, 0);
    chk(wr_resp, 2'h2);
    wrap_up;
  end
endmodule
